// File: core/lpo_pkg.sv
// shared constants for the lin position and otp command decoder
package lpo_pkg;
    // frame identifiers and command codes
    localparam logic [5:0] DIAG_ID        = 6'h3C;
    localparam logic [7:0] APP_PREFIX     = 8'h80;
    localparam logic [6:0] CMD_OTP        = 7'h10;
    localparam logic [6:0] CMD_MOVE       = 7'h0B;
    localparam logic [7:0] FILL_BYTE      = 8'hFF;
    localparam logic [3:0] OTP_ADDR_FILL  = 4'hF;
    localparam logic [1:0] GP_ID_TOP      = 2'h2;
    localparam logic [3:0] LEN2           = 4'h2;
    localparam logic [3:0] LEN4           = 4'h4;
    localparam logic [3:0] LEN8           = 4'h8;
    localparam logic [3:0] MAX_BYTES      = 4'h9;
    localparam logic [7:0] CSUM_GOOD      = 8'hFF;
    // register byte offsets
    localparam logic [7:0] REG_NODE_CFG   = 8'h00;
    localparam logic [7:0] REG_ID_CFG     = 8'h04;
    localparam logic [7:0] REG_TARGET     = 8'h08;
    localparam logic [7:0] REG_OTP_LAST   = 8'h0C;
    localparam logic [7:0] REG_REJECT     = 8'h10;
    // field positions
    localparam int STEP_SEL_POS   = 8;
    localparam int SHORT_ID_POS   = 8;
    localparam int GP_ID_POS      = 16;
    localparam int MULTI_ID_POS   = 24;
    localparam int MOVE_SEEN_POS  = 16;
    localparam int OTP_SEEN_POS   = 17;
    localparam int OTP_DATA_POS   = 8;
    // values after reset
    localparam logic [6:0] NODE_ADDR_RST  = 7'h00;
    localparam logic [1:0] STEP_SEL_RST   = 2'h0;
    localparam logic [5:0] ABS_ID_RST     = 6'h10;
    localparam logic [5:0] SHORT_ID_RST   = 6'h11;
    localparam logic [5:0] GP_ID_RST      = 6'h20;
    localparam logic [5:0] MULTI_ID_RST   = 6'h30;
    // half-step shift per step resolution: 1/2, 1/4, 1/8, 1/16
    localparam logic [3:0][1:0] HALF_SHIFT = {2'h3, 2'h2, 2'h1, 2'h0};
endpackage : lpo_pkg

// File: core/lpo_frame_capture.sv
// collects one lin frame and checks identifier parity and classic checksum
`timescale 1ns/10ps
module lpo_frame_capture
    import lpo_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // byte stream from the lin link layer
    input  wire logic             lin_frame_start,
    input  wire logic [7:0]       lin_pid,
    input  wire logic             lin_byte_valid,
    input  wire logic [7:0]       lin_byte,
    input  wire logic             lin_frame_end,
    // captured frame
    output logic                  fr_ok,
    output logic                  fr_bad,
    output logic [5:0]            fr_id,
    output logic [3:0]            fr_len,
    output logic [7:0][7:0]       fr_data
);
    logic [7:0] mem_q [0:7];
    logic [7:0] pid_q;
    logic [3:0] cnt_q;
    logic [7:0] sum_q;
    logic       over_q;
    logic [8:0] sum_w;
    logic       par_ok;
    logic       len_ok;

    assign sum_w  = {1'b0, sum_q} + {1'b0, lin_byte};
    assign par_ok = (pid_q[6] == (pid_q[0] ^ pid_q[1] ^ pid_q[2] ^ pid_q[4]))
                  && (pid_q[7] == ~(pid_q[1] ^ pid_q[3] ^ pid_q[4] ^ pid_q[5]));
    assign len_ok = (cnt_q == LEN2 + 4'h1) || (cnt_q == LEN4 + 4'h1) || (cnt_q == LEN8 + 4'h1);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pid_q  <= 8'h00;
            cnt_q  <= 4'h0;
            sum_q  <= 8'h00;
            over_q <= 1'b0;
        end else if (lin_frame_start) begin
            pid_q  <= lin_pid;
            cnt_q  <= 4'h0;
            sum_q  <= 8'h00;
            over_q <= 1'b0;
        end else if (lin_byte_valid) begin
            // end-around carry keeps the classic checksum rule
            sum_q <= sum_w[7:0] + {7'h00, sum_w[8]};
            if (cnt_q == MAX_BYTES) begin
                over_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (lin_byte_valid && !lin_frame_start && cnt_q < LEN8) begin
            mem_q[cnt_q[2:0]] <= lin_byte;
        end
    end

    // checksum byte is summed in, so a clean frame totals all ones
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fr_ok  <= 1'b0;
            fr_bad <= 1'b0;
            fr_id  <= 6'h00;
            fr_len <= 4'h0;
        end else begin
            fr_ok  <= lin_frame_end && par_ok && len_ok && !over_q && sum_q == CSUM_GOOD;
            fr_bad <= lin_frame_end && !(par_ok && len_ok && !over_q && sum_q == CSUM_GOOD);
            if (lin_frame_end) begin
                fr_id  <= pid_q[5:0];
                fr_len <= cnt_q - 4'h1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            fr_data[i] = mem_q[i];
        end
    end
endmodule : lpo_frame_capture

// File: core/lpo_command_decoder.sv
// lin position and otp command decoder with avalon register slave
// Operation
// - otp request: diagnostic id, prefix 0x80, command 0x10, value fifth, three 0xFF fill
// - otp byte address top bit arrives inverted and is complemented before use
// - zero broadcast flag makes every node program otp regardless of address
// - two-byte absolute move on direct id with bit 5 zero, high byte first
// - four-byte general move: id bits 5:4 = 10, command 0x0B, address, target
// - zero broadcast in general move makes every node take the target
// - two-motor frame on diagnostic id: prefix, 0x0B, then address plus target pairs
// - node loads only the target paired with its own matching address field
// - full targets are signed sixteen-bit two's complement values
// - short target is eleven bits in half-step units
// - short move keeps step resolution but lands on a half-step multiple
// - short frames match four address bits against stored physical address low bits
// - short frame: target 10:8 in bits 7:5, broadcast bit 4, address 3:0
// - zero broadcast in short frame makes every node take the short target
// - identifier parity bits are checked on every frame
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
module lpo_command_decoder
    import lpo_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // avalon-mm slave
    input  wire logic [7:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest,
    // lin link layer byte stream
    input  wire logic             lin_frame_start,
    input  wire logic [7:0]       lin_pid,
    input  wire logic             lin_byte_valid,
    input  wire logic [7:0]       lin_byte,
    input  wire logic             lin_frame_end,
    // positioner target
    output logic                  move_valid,
    output logic [15:0]           move_target,
    output logic                  move_short,
    // otp programming request
    output logic                  otp_write,
    output logic [3:0]            otp_byte_addr,
    output logic [7:0]            otp_byte_data
);
    logic             fr_ok;
    logic             fr_bad;
    logic [5:0]       fr_id;
    logic [3:0]       fr_len;
    logic [7:0][7:0]  d;

    logic [6:0]       node_addr_q;
    logic [1:0]       step_resolution_select_q;
    logic [5:0]       abs_id_q;
    logic [5:0]       short_id_q;
    logic [5:0]       gp_id_q;
    logic [5:0]       multi_id_q;
    logic             move_seen_q;
    logic             otp_seen_q;
    logic [7:0]       reject_cnt_q;

    logic             otp_hit_d;
    logic [3:0]       otp_addr_d;
    logic             mv_hit_d;
    logic             mv_short_d;
    logic [15:0]      mv_pos_d;
    logic [10:0]      pos11_d;
    logic [3:0]       stored_physical_addr_low;
    logic             bus_req;
    logic             bus_done;
    logic [31:0]      wmask;
    logic [31:0]      rdata_d;

    lpo_frame_capture u_capture (
        .clk             (clk),
        .rst_b           (rst_b),
        .lin_frame_start (lin_frame_start),
        .lin_pid         (lin_pid),
        .lin_byte_valid  (lin_byte_valid),
        .lin_byte        (lin_byte),
        .lin_frame_end   (lin_frame_end),
        .fr_ok           (fr_ok),
        .fr_bad          (fr_bad),
        .fr_id           (fr_id),
        .fr_len          (fr_len),
        .fr_data         (d)
    );

    assign stored_physical_addr_low = node_addr_q[3:0];

    // frame decode; the id checks run in a fixed order so overlapping ids pick the first
    always_comb begin
        otp_hit_d  = 1'b0;
        otp_addr_d = 4'h0;
        mv_hit_d   = 1'b0;
        mv_short_d = 1'b0;
        mv_pos_d   = 16'h0000;
        pos11_d    = 11'h000;
        if (fr_ok) begin
            if (fr_id == DIAG_ID && fr_len == LEN8 && d[0] == APP_PREFIX && d[1][7]) begin
                if (d[1][6:0] == CMD_OTP && d[3][7:4] == OTP_ADDR_FILL && d[5] == FILL_BYTE
                    && d[6] == FILL_BYTE && d[7] == FILL_BYTE
                    && (!d[2][7] || d[2][6:0] == node_addr_q)) begin
                    otp_hit_d  = 1'b1;
                    otp_addr_d = {~d[3][3], d[3][2:0]};
                end else if (d[1][6:0] == CMD_MOVE) begin
                    if (d[2][7] && d[2][6:0] == node_addr_q) begin
                        mv_hit_d = 1'b1;
                        mv_pos_d = {d[3], d[4]};
                    end else if (d[5][7] && d[5][6:0] == node_addr_q) begin
                        mv_hit_d = 1'b1;
                        mv_pos_d = {d[6], d[7]};
                    end
                end
            end else if (fr_id == abs_id_q && !fr_id[5] && fr_len == LEN2) begin
                mv_hit_d = 1'b1;
                mv_pos_d = {d[0], d[1]};
            end else if (fr_id == gp_id_q && fr_id[5:4] == GP_ID_TOP && fr_len == LEN4
                         && d[0] == {1'b1, CMD_MOVE}
                         && (!d[1][7] || d[1][6:0] == node_addr_q)) begin
                mv_hit_d = 1'b1;
                mv_pos_d = {d[2], d[3]};
            end else if (fr_id == short_id_q && !fr_id[5] && fr_len == LEN2
                         && (!d[0][4] || d[0][3:0] == stored_physical_addr_low)) begin
                mv_hit_d   = 1'b1;
                mv_short_d = 1'b1;
                pos11_d    = {d[0][7:5], d[1]};
            end else if (fr_id == multi_id_q && fr_id[5] && (fr_len == LEN4 || fr_len == LEN8)) begin
                // two- and four-motor short frames: first matching pair wins
                for (int i = 0; i < 4; i++) begin
                    if (!mv_hit_d && 4'(2 * i) < fr_len && d[2 * i][4]
                        && d[2 * i][3:0] == stored_physical_addr_low) begin
                        mv_hit_d   = 1'b1;
                        mv_short_d = 1'b1;
                        pos11_d    = {d[2 * i][7:5], d[2 * i + 1]};
                    end
                end
            end
        end
        if (mv_short_d) begin
            // half steps scaled to the programmed resolution keep the end on a half step
            mv_pos_d = 16'({{5{pos11_d[10]}}, pos11_d} <<< HALF_SHIFT[step_resolution_select_q]);
        end
    end

    // outputs toward positioner and otp; only a clean frame gets here
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            move_valid    <= 1'b0;
            move_target   <= 16'h0000;
            move_short    <= 1'b0;
            otp_write     <= 1'b0;
            otp_byte_addr <= 4'h0;
            otp_byte_data <= 8'h00;
        end else begin
            move_valid <= mv_hit_d;
            otp_write  <= otp_hit_d;
            if (mv_hit_d) begin
                move_target <= mv_pos_d;
                move_short  <= mv_short_d;
            end
            if (otp_hit_d) begin
                otp_byte_addr <= otp_addr_d;
                otp_byte_data <= d[4];
            end
        end
    end

    // avalon: one wait cycle per access, then a single completing edge
    assign bus_req  = avs_read || avs_write;
    assign bus_done = bus_req && !avs_waitrequest;
    assign wmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            REG_NODE_CFG: begin
                rdata_d[6:0]                       = node_addr_q;
                rdata_d[STEP_SEL_POS +: 2]         = step_resolution_select_q;
            end
            REG_ID_CFG: begin
                rdata_d[5:0]                       = abs_id_q;
                rdata_d[SHORT_ID_POS +: 6]         = short_id_q;
                rdata_d[GP_ID_POS +: 6]            = gp_id_q;
                rdata_d[MULTI_ID_POS +: 6]         = multi_id_q;
            end
            REG_TARGET: begin
                rdata_d[15:0]                      = move_target;
                rdata_d[MOVE_SEEN_POS]             = move_seen_q;
                rdata_d[OTP_SEEN_POS]              = otp_seen_q;
            end
            REG_OTP_LAST: begin
                rdata_d[3:0]                       = otp_byte_addr;
                rdata_d[OTP_DATA_POS +: 8]         = otp_byte_data;
            end
            REG_REJECT: begin
                rdata_d[7:0]                       = reject_cnt_q;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            node_addr_q              <= NODE_ADDR_RST;
            step_resolution_select_q <= STEP_SEL_RST;
            abs_id_q                 <= ABS_ID_RST;
            short_id_q               <= SHORT_ID_RST;
            gp_id_q                  <= GP_ID_RST;
            multi_id_q               <= MULTI_ID_RST;
        end else if (bus_done && avs_write) begin
            if (avs_address == REG_NODE_CFG && avs_byteenable[0]) begin
                node_addr_q <= avs_writedata[6:0];
            end
            if (avs_address == REG_NODE_CFG && avs_byteenable[1]) begin
                step_resolution_select_q <= avs_writedata[STEP_SEL_POS +: 2];
            end
            if (avs_address == REG_ID_CFG) begin
                abs_id_q   <= (avs_writedata[5:0] & wmask[5:0]) | (abs_id_q & ~wmask[5:0]);
                short_id_q <= avs_byteenable[1] ? avs_writedata[SHORT_ID_POS +: 6] : short_id_q;
                gp_id_q    <= avs_byteenable[2] ? avs_writedata[GP_ID_POS +: 6] : gp_id_q;
                multi_id_q <= avs_byteenable[3] ? avs_writedata[MULTI_ID_POS +: 6] : multi_id_q;
            end
        end
    end

    // sticky status: a new event in the clearing cycle wins over the clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            move_seen_q  <= 1'b0;
            otp_seen_q   <= 1'b0;
            reject_cnt_q <= 8'h00;
        end else begin
            if (mv_hit_d) begin
                move_seen_q <= 1'b1;
            end else if (bus_done && avs_write && avs_address == REG_TARGET
                         && avs_byteenable[2] && avs_writedata[MOVE_SEEN_POS]) begin
                move_seen_q <= 1'b0;
            end
            if (otp_hit_d) begin
                otp_seen_q <= 1'b1;
            end else if (bus_done && avs_write && avs_address == REG_TARGET
                         && avs_byteenable[2] && avs_writedata[OTP_SEEN_POS]) begin
                otp_seen_q <= 1'b0;
            end
            if (fr_bad) begin
                reject_cnt_q <= (reject_cnt_q == 8'hFF) ? reject_cnt_q : reject_cnt_q + 8'h01;
            end else if (bus_done && avs_write && avs_address == REG_REJECT) begin
                reject_cnt_q <= 8'h00;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_otp_frame;
        fr_ok && fr_id == DIAG_ID && fr_len == LEN8 && d[0] == APP_PREFIX && d[1] == {1'b1, CMD_OTP}
        && d[3][7:4] == OTP_ADDR_FILL && d[5] == FILL_BYTE && d[6] == FILL_BYTE && d[7] == FILL_BYTE;
    endsequence

    chk_otp_frame_form: assert property (otp_write |-> $past(fr_ok && fr_id == DIAG_ID && d[5] == FILL_BYTE))
        else $error("otp write without a valid otp frame");
    chk_otp_addr_flip: assert property (s_otp_frame ##0 (!d[2][7] || d[2][6:0] == node_addr_q)
                                        |=> otp_write && otp_byte_addr[3] == ~$past(d[3][3]))
        else $error("otp address top bit not complemented");
    chk_otp_broadcast: assert property (s_otp_frame ##0 !d[2][7] |=> otp_write && otp_byte_data == $past(d[4]))
        else $error("broadcast otp frame ignored");
    chk_abs_direct: assert property (fr_ok && fr_id == abs_id_q && !fr_id[5] && fr_len == LEN2
                                      |=> move_valid && move_target == {$past(d[0]), $past(d[1])})
        else $error("direct absolute move not taken");
    chk_gp_broadcast: assert property (fr_ok && fr_id != DIAG_ID && fr_id != abs_id_q && fr_id == gp_id_q
                                       && fr_id[5:4] == GP_ID_TOP && fr_len == LEN4
                                       && d[0] == {1'b1, CMD_MOVE} && !d[1][7]
                                       |=> move_valid && !move_short)
        else $error("broadcast general move ignored");
    chk_pair_select: assert property (fr_ok && fr_id == DIAG_ID && fr_len == LEN8 && d[0] == APP_PREFIX
                                      && d[1] == {1'b1, CMD_MOVE} && !(d[2][7] && d[2][6:0] == node_addr_q)
                                      && d[5][7] && d[5][6:0] == node_addr_q
                                      |=> move_valid && move_target == {$past(d[6]), $past(d[7])})
        else $error("second motor target not selected");
    chk_short_halfstep: assert property (move_valid && move_short
                                         |-> (move_target & ((16'h0001 << HALF_SHIFT[step_resolution_select_q])
                                             - 16'h0001)) == 16'h0000)
        else $error("short target not on a half step");
    chk_bad_frame: assert property (fr_bad |=> !move_valid && !otp_write && $stable(move_target))
        else $error("bad frame produced an action");
    chk_bus_answer: assert property ($rose(bus_req) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("avalon answer not after one wait cycle");
endmodule : lpo_command_decoder

// File: test/lpo_lin_master.sv
// lin master node model: sends frames as a link-layer byte stream
`timescale 1ns/10ps
module lpo_lin_master (
    // clock
    input  wire logic       clk,
    // frame byte stream
    output logic            lin_frame_start,
    output logic [7:0]      lin_pid,
    output logic            lin_byte_valid,
    output logic [7:0]      lin_byte,
    output logic            lin_frame_end
);
    initial begin
        lin_frame_start = 1'b0;
        lin_pid = 8'h00;
        lin_byte_valid = 1'b0;
        lin_byte = 8'h00;
        lin_frame_end = 1'b0;
    end
    // bad[0] spoils the checksum, bad[1] the parity; data bytes left-aligned in d
    task automatic send(input logic [5:0] id, input int n, input logic [63:0] d, input logic [1:0] bad);
        logic [8:0] s;
        logic [7:0] pid;
        s = 9'h000;
        pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
        lin_frame_start <= 1'b1;
        lin_pid <= pid ^ {bad[1], 7'h00};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            lin_frame_start <= 1'b0;
            lin_byte_valid <= 1'b1;
            lin_byte <= d[63 - 8 * i -: 8];
            s = {1'b0, s[7:0]} + {1'b0, d[63 - 8 * i -: 8]};
            s = {1'b0, s[7:0]} + {8'h00, s[8]};
        end
        @(posedge clk);
        lin_byte <= ~s[7:0] ^ {7'h00, bad[0]};
        @(posedge clk);
        lin_byte_valid <= 1'b0;
        lin_byte <= ~lin_byte; // released line shows no stale value
        lin_frame_end <= 1'b1;
        @(posedge clk);
        lin_frame_end <= 1'b0;
    endtask : send
endmodule : lpo_lin_master

// File: test/lpo_command_decoder_tb.sv
// self-checking bench for the lin position and otp command decoder
`timescale 1ns/10ps
module lpo_command_decoder_tb;
    import lpo_pkg::*;
    logic clk, rst_b, avs_read, avs_write, avs_waitrequest, fs, bv, fe;
    logic move_valid, move_short, otp_write;
    logic [7:0] avs_address, pid, lb;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, otp_byte_addr;
    logic [15:0] move_target;
    logic [7:0] otp_byte_data;
    int err_total, checked;
    lpo_lin_master lin (.clk(clk), .lin_frame_start(fs), .lin_pid(pid), .lin_byte_valid(bv),
        .lin_byte(lb), .lin_frame_end(fe));
    lpo_command_decoder dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lin_frame_start(fs),
        .lin_pid(pid), .lin_byte_valid(bv), .lin_byte(lb), .lin_frame_end(fe), .move_valid(move_valid),
        .move_target(move_target), .move_short(move_short), .otp_write(otp_write),
        .otp_byte_addr(otp_byte_addr), .otp_byte_data(otp_byte_data));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic check(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    // one avalon access; waits for waitrequest low under a bound
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                print_verdict();
            end
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    // sends a frame and counts output pulses; a refused frame must give none
    task automatic frame(input logic [5:0] id, input int n, input logic [63:0] d, input logic [1:0] bad,
                         input int emv, input int eot);
        int mv, ot;
        mv = 0;
        ot = 0;
        lin.send(id, n, d, bad);
        repeat (5) begin
            @(posedge clk);
            mv += (move_valid === 1'b1);
            ot += (otp_write === 1'b1);
        end
        check(mv == emv && ot == eot, "pulse count");
    endtask : frame
    initial begin
        err_total = 0;
        checked = 0;
        rst_b = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'hF;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b0, REG_ID_CFG, 32'h0);
        check(rd === {2'h0, MULTI_ID_RST, 2'h0, GP_ID_RST, 2'h0, SHORT_ID_RST, 2'h0, ABS_ID_RST}, "id cfg");
        bus(1'b0, 8'h14, 32'h0);
        check(rd === 32'h0, "unmapped read");
        bus(1'b1, REG_NODE_CFG, 32'h0000_0175);
        bus(1'b0, REG_NODE_CFG, 32'h0);
        check(rd === 32'h0000_0175, "node cfg");
        $display("test registers done");
        frame(DIAG_ID, 8, 64'h8090_F5F3_5AFF_FFFF, 2'h0, 0, 1);
        check(otp_byte_addr === 4'hB && otp_byte_data === 8'h5A, "otp addr");
        frame(DIAG_ID, 8, 64'h8090_22FE_C3FF_FFFF, 2'h0, 0, 1);
        check(otp_byte_addr === 4'h6 && otp_byte_data === 8'hC3, "otp broadcast");
        frame(DIAG_ID, 8, 64'h8090_A2F0_11FF_FFFF, 2'h0, 0, 0);
        check(otp_byte_addr === 4'h6, "otp other node");
        bus(1'b0, REG_OTP_LAST, 32'h0);
        check(rd === 32'h0000_C306, "otp last");
        $display("test otp done");
        frame(ABS_ID_RST, 2, 64'h8001_0000_0000_0000, 2'h0, 1, 0);
        check(move_target === 16'h8001 && move_short === 1'b0, "direct move");
        frame(GP_ID_RST, 4, 64'h8B7F_1234_0000_0000, 2'h0, 1, 0);
        check(move_target === 16'h1234, "general broadcast");
        frame(DIAG_ID, 8, 64'h808B_8311_11F5_2222, 2'h0, 1, 0);
        check(move_target === 16'h2222, "two motor pair");
        $display("test absolute move done");
        frame(SHORT_ID_RST, 2, 64'h9505_0000_0000_0000, 2'h0, 1, 0);
        check(move_target === 16'hF80A && move_short === 1'b1, "short move");
        frame(SHORT_ID_RST, 2, 64'h6321_0000_0000_0000, 2'h0, 1, 0);
        check(move_target === 16'h0642, "short broadcast");
        frame(SHORT_ID_RST, 2, 64'h9A11_0000_0000_0000, 2'h0, 0, 0);
        frame(MULTI_ID_RST, 8, 64'h1100_1200_3580_1577, 2'h0, 1, 0);
        check(move_target === 16'h0300 && move_short === 1'b1, "multi short move");
        $display("test short move done");
        frame(ABS_ID_RST, 2, 64'h7777_0000_0000_0000, 2'h1, 0, 0);
        frame(ABS_ID_RST, 2, 64'h7777_0000_0000_0000, 2'h2, 0, 0);
        check(move_target === 16'h0300, "target kept");
        bus(1'b0, REG_REJECT, 32'h0);
        check(rd[7:0] === 8'h02, "reject count");
        bus(1'b0, REG_TARGET, 32'h0);
        check(rd === 32'h0003_0300, "status flags");
        bus(1'b1, REG_TARGET, 32'h0003_0000);
        bus(1'b0, REG_TARGET, 32'h0);
        check(rd === 32'h0000_0300, "flags cleared");
        $display("test bad frames done");
        print_verdict();
    end
endmodule : lpo_command_decoder_tb
